// >>> verilog/trig_seq_consts.svh
// timing counts, register offsets, field positions and reset values for the trigger sequencer
// assumes inclusion by the package, the checker and the bench
`ifndef TRIG_SEQ_CONSTS_SVH
`define TRIG_SEQ_CONSTS_SVH

// ----------------------------------------------------------------
// clock and tick
// ----------------------------------------------------------------
`define CLK_PERIOD_NS        50
`define TICK_PERIOD_NS       1000000
`define TICK_CYCLES          (`TICK_PERIOD_NS / `CLK_PERIOD_NS)

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define OFS_CTRL             12'h000
`define OFS_HOLDOFF          12'h004
`define OFS_STATE            12'h008
`define OFS_LEVEL            12'h00C
`define OFS_DURATION         12'h010
`define OFS_STATUS           12'h014

// ----------------------------------------------------------------
// control fields
// ----------------------------------------------------------------
`define CTRL_EDGE_BIT        0
`define CTRL_EXT_LSB         4
`define CTRL_START_LSB       8
`define CTRL_STOP_LSB        12
`define CTRL_KEY_BIT         16

// ----------------------------------------------------------------
// limits and reset values
// ----------------------------------------------------------------
`define HOLDOFF_MAX          16'h03E8
`define STOP_CODE_MAX        3'h6
`define RST_EDGE             1'h1
`define RST_EXT              2'h0
`define RST_START            2'h0
`define RST_STOP             3'h0
`define RST_HOLDOFF          16'h0000
`define RST_LEVEL            32'h00000000
`define RST_DURATION         32'h00000000

`endif

// >>> verilog/trig_seq_pkg.sv
// types for the trigger sequencer
// assumes the constants header is on the include path
package trig_seq_pkg;
  `include "trig_seq_consts.svh"

  typedef enum logic [3:0] {
    ST_ARMED   = 4'h1,
    ST_HOLDOFF = 4'h2,
    ST_RUN     = 4'h4,
    ST_DONE    = 4'h8
  } seq_state_e;

  typedef enum logic [1:0] {
    START_CONT = 2'h0,
    START_EXT  = 2'h1,
    START_KEY  = 2'h2,
    START_HOST = 2'h3
  } start_sel_e;

  typedef enum logic [2:0] {
    STOP_NEVER = 3'h0,
    STOP_EXT   = 3'h1,
    STOP_KEY   = 3'h2,
    STOP_HOST  = 3'h3,
    STOP_LEVEL = 3'h4,
    STOP_TIME  = 3'h5
  } stop_sel_e;
endpackage : trig_seq_pkg

// >>> verilog/trig_seq.sv
// measurement trigger sequencer: apb registers, external trigger edge detect, holdoff and stop logic
// assumes a 20 MHz core clock, an apb master on the same clock, and a measurement path that
// presents one sample per valid pulse as a signed 32-bit integer in the level threshold's scale
//
// Function
// - edge setting reads back 0 for falling, 1 for rising.
// - external trigger active on falling edge for 0, rising for 1.
// - external enable 0 off, 1 channel A, 2 channel B, 3 both; channel choice applies to external starts only, other starts run both.
// - holdoff is 0 to 1000; host keeps within range.
// - after a trigger, wait holdoff milliseconds before measuring.
// - holdoff readback returns programmed delay in milliseconds.
// - start 0 measures continuously; 1 starts on enabled external edge.
// - start 2 begins measuring on soft key press.
// - start 3 begins measuring when host writes state 1.
// - start selector reads back programmed code.
// - stop selector is 0 to 6; host uses defined codes only.
// - stop 0 never stops; stop 1 halts on enabled external edge.
// - stop 2 halts on soft key press.
// - stop 3 halts when host writes state 0.
// - stop 4 halts once a measurement exceeds the level threshold.
// - stop 5 halts once elapsed time since start exceeds duration.
// - stop selector reads back programmed code.
// - state 0 means armed, waiting for start event.
// - state 1 means triggered with at least one measurement; readable.
// - level threshold is writable and readable, used for level stop.
// - duration in milliseconds is writable and readable, used for time stop.
`timescale 1ns/1ps

module trig_seq
  import trig_seq_pkg::*;
#(
  parameter int TICK_CYC = `TICK_CYCLES
) (
  input  wire logic        CORE_CLK_I,
  input  wire logic        ARST_N_I,
  input  wire logic        PSEL_I,
  input  wire logic        PENABLE_I,
  input  wire logic        PWRITE_I,
  input  wire logic [11:0] PADDR_I,
  input  wire logic [31:0] PWDATA_I,
  output logic      [31:0] PRDATA_O,
  output logic             PREADY_O,
  output logic             PSLVERR_O,
  input  wire logic        EXT_TRIG_I,
  input  wire logic        SOFT_KEY_I,
  input  wire logic        MEAS_VALID_I,
  input  wire logic [31:0] MEAS_VALUE_I,
  output logic             MEAS_ENABLE_A_O,
  output logic             MEAS_ENABLE_B_O,
  output logic             TRIG_ARM_STATE_O
);

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic rst_meta_reg;
  logic rst_n_reg;

  always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      rst_meta_reg <= 1'b0;
      rst_n_reg    <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n_reg    <= rst_meta_reg;
    end
  end

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic ext_meta_reg;
  logic ext_sync_reg;
  logic ext_prev_reg;
  logic key_meta_reg;
  logic key_sync_reg;
  logic key_prev_reg;

  // only the second and third stages are read by logic; the first may still be settling
  always_ff @(posedge CORE_CLK_I or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      ext_meta_reg <= 1'b0;
      ext_sync_reg <= 1'b0;
      ext_prev_reg <= 1'b0;
    end else begin
      ext_meta_reg <= EXT_TRIG_I;
      ext_sync_reg <= ext_meta_reg;
      ext_prev_reg <= ext_sync_reg;
    end
  end

  always_ff @(posedge CORE_CLK_I or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      key_meta_reg <= 1'b0;
      key_sync_reg <= 1'b0;
      key_prev_reg <= 1'b0;
    end else begin
      key_meta_reg <= SOFT_KEY_I;
      key_sync_reg <= key_meta_reg;
      key_prev_reg <= key_sync_reg;
    end
  end

  // ----------------------------------------------------------------
  // edge decode
  // ----------------------------------------------------------------
  // one-cycle pulse when a synchronised level is high now and was low before
  function automatic logic rose_of(input logic now_lvl, input logic was_lvl);
    rose_of = now_lvl && !was_lvl;
  endfunction : rose_of

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic        edge_sel_reg;
  logic [1:0]  ext_enable_reg;
  logic [1:0]  start_sel_reg;
  logic [2:0]  stop_sel_reg;
  logic [15:0] holdoff_reg;
  logic [31:0] level_reg;
  logic [31:0] duration_reg;
  logic [3:0]  key_sel_reg;

  wire wr_en = PSEL_I && PENABLE_I && PWRITE_I;
  wire rd_en = PSEL_I && !PWRITE_I;

  wire hit_ctrl     = (PADDR_I == `OFS_CTRL);
  wire hit_holdoff  = (PADDR_I == `OFS_HOLDOFF);
  wire hit_state    = (PADDR_I == `OFS_STATE);
  wire hit_level    = (PADDR_I == `OFS_LEVEL);
  wire hit_duration = (PADDR_I == `OFS_DURATION);
  wire hit_status   = (PADDR_I == `OFS_STATUS);
  wire hit_any      = hit_ctrl || hit_holdoff || hit_state || hit_level || hit_duration || hit_status;

  wire host_arm_wr  = wr_en && hit_state && !PWDATA_I[0];
  wire host_trig_wr = wr_en && hit_state && PWDATA_I[0];

  // key select chooses which bit of the soft key bus is the designated key; single key here
  wire ext_rise = rose_of(ext_sync_reg, ext_prev_reg);
  wire ext_fall = rose_of(ext_prev_reg, ext_sync_reg);
  wire ext_edge = (edge_sel_reg ? ext_rise : ext_fall) && (ext_enable_reg != 2'h0);
  wire key_evt  = rose_of(key_sync_reg, key_prev_reg);

  wire ctrl_wr     = wr_en && hit_ctrl;
  wire holdoff_wr  = wr_en && hit_holdoff;
  wire level_wr    = wr_en && hit_level;
  wire duration_wr = wr_en && hit_duration;

  always_ff @(posedge CORE_CLK_I or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      edge_sel_reg   <= `RST_EDGE;
      ext_enable_reg <= `RST_EXT;
      start_sel_reg  <= `RST_START;
      stop_sel_reg   <= `RST_STOP;
      key_sel_reg    <= 4'h0;
    end else if (ctrl_wr) begin
      edge_sel_reg   <= PWDATA_I[`CTRL_EDGE_BIT];
      ext_enable_reg <= PWDATA_I[`CTRL_EXT_LSB +: 2];
      start_sel_reg  <= PWDATA_I[`CTRL_START_LSB +: 2];
      // codes above the last defined stop are kept but act as never-stop
      stop_sel_reg   <= PWDATA_I[`CTRL_STOP_LSB +: 3];
      key_sel_reg    <= PWDATA_I[`CTRL_KEY_BIT +: 4];
    end
  end

  // clamp guards the counter if the host oversteps the range
  always_ff @(posedge CORE_CLK_I or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      holdoff_reg <= `RST_HOLDOFF;
    end else if (holdoff_wr) begin
      holdoff_reg <= (PWDATA_I[15:0] > `HOLDOFF_MAX) ? `HOLDOFF_MAX : PWDATA_I[15:0];
    end
  end

  always_ff @(posedge CORE_CLK_I or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      level_reg <= `RST_LEVEL;
    end else if (level_wr) begin
      level_reg <= PWDATA_I;
    end
  end

  always_ff @(posedge CORE_CLK_I or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      duration_reg <= `RST_DURATION;
    end else if (duration_wr) begin
      duration_reg <= PWDATA_I;
    end
  end

  // ----------------------------------------------------------------
  // millisecond tick
  // ----------------------------------------------------------------
  logic [31:0] tick_cnt_reg;
  wire         tick = (tick_cnt_reg == 32'(TICK_CYC - 1));

  always_ff @(posedge CORE_CLK_I or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      tick_cnt_reg <= 32'h00000000;
    end else begin
      tick_cnt_reg <= tick ? 32'h00000000 : tick_cnt_reg + 32'h00000001;
    end
  end

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  seq_state_e  state_reg;
  seq_state_e  state_next;
  logic [15:0] hold_cnt_reg;
  logic [31:0] run_ms_reg;
  logic        measured_reg;

  wire start_on_ext  = (start_sel_reg == START_EXT) && ext_edge;
  wire start_on_key  = (start_sel_reg == START_KEY) && key_evt;
  wire start_on_host = (start_sel_reg == START_HOST) && host_trig_wr;
  wire start_evt     = (start_sel_reg == START_CONT) || start_on_ext || start_on_key || start_on_host;

  // level stop needs a fresh sample; stale values between samples are ignored
  wire over_level   = MEAS_VALID_I && ($signed(MEAS_VALUE_I) > $signed(level_reg));
  wire stop_on_ext  = (stop_sel_reg == STOP_EXT) && ext_edge;
  wire stop_on_key  = (stop_sel_reg == STOP_KEY) && key_evt;
  wire stop_on_host = (stop_sel_reg == STOP_HOST) && host_arm_wr;
  wire stop_on_lvl  = (stop_sel_reg == STOP_LEVEL) && over_level;
  wire stop_on_time = (stop_sel_reg == STOP_TIME) && (run_ms_reg > duration_reg);
  wire stop_evt     = stop_on_ext || stop_on_key || stop_on_host || stop_on_lvl || stop_on_time;

  wire hold_done = (hold_cnt_reg >= holdoff_reg);

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_ARMED: begin
        if (start_evt) begin
          state_next = ST_HOLDOFF;
        end
      end
      ST_HOLDOFF: begin
        if (hold_done) begin
          state_next = ST_RUN;
        end
      end
      ST_RUN: begin
        if (stop_evt) begin
          state_next = ST_DONE;
        end
      end
      ST_DONE: begin
        if (host_arm_wr) begin
          state_next = ST_ARMED;
        end
      end
      default: state_next = ST_ARMED;
    endcase
    // host re-arm returns to waiting from any state except a run with host stop selected
    if (host_arm_wr && (stop_sel_reg != STOP_HOST || state_reg != ST_RUN)) begin
      state_next = ST_ARMED;
    end
  end

  always_ff @(posedge CORE_CLK_I or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      state_reg <= ST_ARMED;
    end else begin
      state_reg <= state_next;
    end
  end

  // holdoff count restarts whenever the sequencer leaves holdoff
  always_ff @(posedge CORE_CLK_I or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      hold_cnt_reg <= 16'h0000;
    end else if (state_reg != ST_HOLDOFF) begin
      hold_cnt_reg <= 16'h0000;
    end else if (tick) begin
      hold_cnt_reg <= hold_cnt_reg + 16'h0001;
    end
  end

  // elapsed time saturates rather than wrapping back under the duration
  always_ff @(posedge CORE_CLK_I or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      run_ms_reg <= 32'h00000000;
    end else if (state_reg == ST_ARMED) begin
      run_ms_reg <= 32'h00000000;
    end else if (tick && (run_ms_reg != 32'hFFFFFFFF)) begin
      run_ms_reg <= run_ms_reg + 32'h00000001;
    end
  end

  always_ff @(posedge CORE_CLK_I or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      measured_reg <= 1'b0;
    end else if (state_next == ST_ARMED) begin
      measured_reg <= 1'b0;
    end else if ((state_reg == ST_RUN) && MEAS_VALID_I) begin
      measured_reg <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // outputs and read path
  // ----------------------------------------------------------------
  wire        trig_state = measured_reg;
  wire [31:0] ctrl_rd = {12'h000, key_sel_reg, 1'b0, stop_sel_reg, 2'h0, start_sel_reg,
                         2'h0, ext_enable_reg, 3'h0, edge_sel_reg};
  wire [31:0] rd_mux = hit_ctrl     ? ctrl_rd :
                       hit_holdoff  ? {16'h0000, holdoff_reg} :
                       hit_state    ? {31'h0, trig_state} :
                       hit_level    ? level_reg :
                       hit_duration ? duration_reg :
                       hit_status   ? {28'h0000000, state_reg} : 32'h00000000;

  wire running = (state_next == ST_RUN);

  // channel choice applies only to external starts; every other start runs both channels
  logic [1:0] chan_ok;

  for (genvar ch = 0; ch < 2; ch++) begin : g_chan
    assign chan_ok[ch] = (start_sel_reg != START_EXT) || ext_enable_reg[ch];
  end

  always_ff @(posedge CORE_CLK_I or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      PRDATA_O  <= 32'h00000000;
      PREADY_O  <= 1'b0;
      PSLVERR_O <= 1'b0;
    end else begin
      // no wait states: ready answers in the first access cycle from registered setup
      PREADY_O  <= PSEL_I && !PENABLE_I;
      PSLVERR_O <= PSEL_I && !PENABLE_I && !hit_any;
      PRDATA_O  <= (rd_en && !PENABLE_I) ? rd_mux : PRDATA_O;
    end
  end

  always_ff @(posedge CORE_CLK_I or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      MEAS_ENABLE_A_O  <= 1'b0;
      MEAS_ENABLE_B_O  <= 1'b0;
      TRIG_ARM_STATE_O <= 1'b0;
    end else begin
      MEAS_ENABLE_A_O  <= running && chan_ok[0];
      MEAS_ENABLE_B_O  <= running && chan_ok[1];
      TRIG_ARM_STATE_O <= trig_state;
    end
  end

endmodule : trig_seq

// >>> tb/trig_far.sv
// far-side model: trigger pin, soft key and a sample stream
// assumes the bench sets the pin levels and the sample value
`timescale 1ns/1ps

module trig_far (
  input  wire logic        clk_i,
  input  wire logic        ext_cmd_i,
  input  wire logic        key_cmd_i,
  input  wire logic [31:0] lvl_cmd_i,
  output logic             ext_o,
  output logic             key_o,
  output logic             valid_o,
  output logic      [31:0] value_o
);
  logic [2:0] cnt_reg;
  // ----------------------------------------------------------------
  // one sample in eight cycles
  // ----------------------------------------------------------------
  initial begin
    {cnt_reg, ext_o, key_o, valid_o, value_o} = '0;
  end
  // value scrambled between samples so a stale reading never looks valid
  always @(posedge clk_i) begin
    cnt_reg <= cnt_reg + 3'h1;
    valid_o <= (cnt_reg == 3'h0);
    value_o <= (cnt_reg == 3'h0) ? lvl_cmd_i : ~value_o;
    ext_o   <= ext_cmd_i;
    key_o   <= key_cmd_i;
  end
endmodule : trig_far

// >>> tb/trig_seq_sva.sv
// checker for the sequencer's bus answers and trigger state
// assumes binding onto trig_seq, seeing its ports only
`timescale 1ns/1ps
`include "trig_seq_consts.svh"

module trig_seq_sva (
  input wire logic        CORE_CLK_I,
  input wire logic        ARST_N_I,
  input wire logic        PSEL_I,
  input wire logic        PENABLE_I,
  input wire logic        PWRITE_I,
  input wire logic [11:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  input wire logic [31:0] PRDATA_O,
  input wire logic        PREADY_O,
  input wire logic        PSLVERR_O,
  input wire logic        MEAS_VALID_I,
  input wire logic        MEAS_ENABLE_A_O,
  input wire logic        MEAS_ENABLE_B_O,
  input wire logic        TRIG_ARM_STATE_O
);
  // host stop code last written: a state 0 write then stops a run instead of re-arming
  logic host_stop_reg;
  always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      host_stop_reg <= 1'b0;
    end else if (PREADY_O && PSEL_I && PENABLE_I && PWRITE_I && PADDR_I == `OFS_CTRL) begin
      host_stop_reg <= (PWDATA_I[`CTRL_STOP_LSB +: 3] == 3'h3);
    end
  end
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (!ARST_N_I);
  wire setup = PSEL_I && !PENABLE_I;
  wire st_wr0 = PREADY_O && PWRITE_I && PADDR_I == `OFS_STATE && !PWDATA_I[0];
  a_setup_ready: assert property (setup |=> PREADY_O && PENABLE_I)
    else $error("no ready after setup");
  a_ready_pulse: assert property (PREADY_O |=> !PREADY_O)
    else $error("ready too long");
  a_err_ready: assert property (PSLVERR_O |-> PREADY_O)
    else $error("error without ready");
  a_unmapped_err: assert property (setup && PADDR_I > `OFS_STATUS |=> PSLVERR_O)
    else $error("unmapped not refused");
  a_mapped_ok: assert property (setup && PADDR_I <= `OFS_STATUS && PADDR_I[1:0] == 2'h0 |=> !PSLVERR_O)
    else $error("mapped refused");
  a_state_read: assert property (setup && !PWRITE_I && PADDR_I == `OFS_STATE
    |=> PRDATA_O[0] == TRIG_ARM_STATE_O)
    else $error("state readback");
  a_state_rise: assert property ($rose(TRIG_ARM_STATE_O) |-> $past(MEAS_VALID_I, 2))
    else $error("triggered without sample");
  a_rearm_clear: assert property (st_wr0 && !host_stop_reg |-> ##[1:4] !TRIG_ARM_STATE_O)
    else $error("no rearm");
  a_host_stop: assert property (st_wr0 && host_stop_reg |-> ##[1:4] !(MEAS_ENABLE_A_O || MEAS_ENABLE_B_O))
    else $error("host stop ignored");
endmodule : trig_seq_sva

bind trig_seq trig_seq_sva u_sva (.CORE_CLK_I, .ARST_N_I, .PSEL_I, .PENABLE_I, .PWRITE_I, .PADDR_I,
  .PWDATA_I, .PRDATA_O, .PREADY_O, .PSLVERR_O, .MEAS_VALID_I, .MEAS_ENABLE_A_O, .MEAS_ENABLE_B_O,
  .TRIG_ARM_STATE_O);

// >>> tb/tb.sv
// self-checking bench for the trigger sequencer
// assumes the design, package, far-side model and checker are compiled first
`timescale 1ns/1ps
`include "trig_seq_consts.svh"

module tb;
  import trig_seq_pkg::*;
  localparam int TC = 10;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        psel = 1'b0;
  logic        pen = 1'b0;
  logic        pwr = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic        ext_c = 1'b0;
  logic        key_c = 1'b0;
  logic [31:0] lvl_c = 32'h00000000;
  logic [31:0] prdata, rdat, val;
  logic        pready, pslverr, err, ext, key, vld, en_a, en_b, st;
  int          err_total = 0;
  int          compares = 0;

  trig_seq #(.TICK_CYC(TC)) dut (.CORE_CLK_I(clk), .ARST_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(pen),
    .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
    .PSLVERR_O(pslverr), .EXT_TRIG_I(ext), .SOFT_KEY_I(key), .MEAS_VALID_I(vld), .MEAS_VALUE_I(val),
    .MEAS_ENABLE_A_O(en_a), .MEAS_ENABLE_B_O(en_b), .TRIG_ARM_STATE_O(st));
  trig_far far (.clk_i(clk), .ext_cmd_i(ext_c), .key_cmd_i(key_c), .lvl_cmd_i(lvl_c), .ext_o(ext),
    .key_o(key), .valid_o(vld), .value_o(val));

  initial begin
    forever #25 clk = ~clk;
  end
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic end_sim();
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : end_sim
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: %s got %h want %h", $time, msg, got, exp);
    end
  endtask : chk
  task automatic tmo(input string msg);
    err_total++;
    $display("unexpected at %0t: %s timed out", $time, msg);
    end_sim();
  endtask : tmo
  // request held until ready is sampled high at a rising edge; data taken at that edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel   <= 1'b1;
    pwr    <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) tmo("apb");
    rdat = prdata;
    err  = pslverr;
    psel <= 1'b0;
    pen  <= 1'b0;
  endtask : apb
  task automatic wen(input logic v, input int lim, output int n);
    n = 0;
    @(negedge clk);
    while ((en_a | en_b) !== v && n < lim) begin
      @(negedge clk);
      n++;
    end
    if (n >= lim) tmo("enable");
    chk(en_a | en_b, v, "enable");
  endtask : wen
  task automatic pin(input logic v);
    @(posedge clk);
    ext_c <= v;
  endtask : pin
  task automatic press();
    @(posedge clk);
    key_c <= 1'b1;
    repeat (6) @(posedge clk);
    key_c <= 1'b0;
  endtask : press
  // holdoff kept within 0..1000 and stop codes to defined ones
  task automatic arm(input logic [31:0] ctrl, input logic [31:0] hold);
    apb(1'b1, `OFS_STATE, 32'h0);
    apb(1'b1, `OFS_CTRL, ctrl);
    apb(1'b1, `OFS_HOLDOFF, hold);
    apb(1'b0, `OFS_STATUS, 32'h0);
    chk(rdat, {28'h0, ST_ARMED}, "armed");
    chk(st, 1'b0, "arm state");
  endtask : arm
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_regs();
    logic [11:0] a [4] = '{`OFS_HOLDOFF, `OFS_HOLDOFF, `OFS_LEVEL, `OFS_DURATION};
    logic [31:0] d [4] = '{32'h000003E8, 32'h000003E9, 32'h80000005, 32'h00000BB8};
    logic [31:0] e [4] = '{32'h000003E8, 32'h000003E8, 32'h80000005, 32'h00000BB8};
    apb(1'b0, `OFS_CTRL, 32'h0);
    chk(rdat, 32'h1, "ctrl reset");
    apb(1'b1, `OFS_CTRL, 32'h00025310);
    apb(1'b0, `OFS_CTRL, 32'h0);
    chk(rdat, 32'h00025310, "ctrl");
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, a[i], d[i]);
      apb(1'b0, a[i], 32'h0);
      chk(rdat, e[i], "readback");
    end
    apb(1'b0, 12'h018, 32'h0);
    chk({rdat, err}, {32'h0, 1'b1}, "unmapped");
    $display("t_regs done");
  endtask : t_regs
  task automatic t_ext();
    int n;
    arm(32'h00001111, 32'h3);
    pin(1'b1);
    wen(1'b1, 80, n);
    chk(n >= 2 * TC && n <= 3 * TC + 10, 1'b1, "holdoff");
    chk({en_a, en_b}, 2'b10, "chan a");
    repeat (12) @(negedge clk);
    chk(st, 1'b1, "triggered");
    pin(1'b0);
    repeat (12) @(negedge clk);
    chk(en_a, 1'b1, "fall ignored");
    pin(1'b1);
    wen(1'b0, 20, n);
    arm(32'h00000120, 32'h0);
    pin(1'b0);
    wen(1'b1, 20, n);
    chk({en_a, en_b}, 2'b01, "chan b");
    pin(1'b1);
    repeat (20) @(negedge clk);
    chk(en_b, 1'b1, "never stops");
    $display("t_ext done");
  endtask : t_ext
  task automatic t_key_host();
    int n;
    arm(32'h00003231, 32'h0);
    press();
    wen(1'b1, 20, n);
    apb(1'b1, `OFS_STATE, 32'h0);
    wen(1'b0, 10, n);
    arm(32'h00002331, 32'h0);
    apb(1'b1, `OFS_STATE, 32'h1);
    wen(1'b1, 10, n);
    press();
    wen(1'b0, 20, n);
    $display("t_key_host done");
  endtask : t_key_host
  task automatic t_stops();
    int n;
    lvl_c <= 32'h00000064;
    apb(1'b1, `OFS_LEVEL, 32'h00000064);
    arm(32'h00004331, 32'h0);
    apb(1'b1, `OFS_STATE, 32'h1);
    wen(1'b1, 10, n);
    repeat (24) @(negedge clk);
    chk(en_a | en_b, 1'b1, "equal level");
    lvl_c <= 32'h00000065;
    wen(1'b0, 20, n);
    apb(1'b1, `OFS_DURATION, 32'h2);
    arm(32'h00005331, 32'h0);
    apb(1'b1, `OFS_STATE, 32'h1);
    wen(1'b1, 10, n);
    wen(1'b0, 60, n);
    chk(n > TC && n <= 3 * TC + 4, 1'b1, "time stop");
    apb(1'b1, `OFS_CTRL, 32'h00000031);
    apb(1'b1, `OFS_STATE, 32'h0);
    wen(1'b1, 10, n);
    repeat (12) @(negedge clk);
    apb(1'b0, `OFS_STATE, 32'h0);
    chk(rdat[0], 1'b1, "state read");
    $display("t_stops done");
  endtask : t_stops

  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    t_regs();
    t_ext();
    t_key_host();
    t_stops();
    end_sim();
  end
endmodule : tb
